// ==== design/uhd_top.sv ====
/*
  Hub descriptor source with an AHB-Lite register slave. Software loads
  the power settings, writes a request (type, byte index) and reads back
  the descriptor byte and a valid flag.
  Assumes a single AHB-Lite master, word-sized single transfers.
*/
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "uhd_cfg.svh"

module uhd_top (
  input  wire logic        hclk,      // Bus clock, 20 MHz
  input  wire logic        hresetn,   // Asynchronous reset, active low
  input  wire logic        hsel,      // Slave select
  input  wire logic [11:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write when high
  input  wire logic [2:0]  hsize,     // Transfer size
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready in
  output logic      [31:0] hrdata,    // Read data
  output logic             hreadyout, // Always ready
  output logic             hresp      // Always OKAY
);

  // ****************************************************************
  // State
  // ****************************************************************
  uhd_pkg::uhd_power_cfg_t cfg_r, cfg_nxt;
  uhd_pkg::uhd_req_t       req_r, req_nxt;
  uhd_pkg::uhd_state_t     st_r, st_nxt;
  logic [11:0]             addr_r, addr_nxt;
  logic                    wr_r, wr_nxt;
  logic [7:0]              byte_r, byte_nxt;
  logic                    hit_r, hit_nxt;
  logic [31:0]             hrdata_r, hrdata_nxt;
  logic [7:0]              rom_byte;
  logic                    rom_hit;
  logic                    take;

  // Register offset decode, used for reads and for writes
  function automatic logic [1:0] dec(input logic [11:0] a);
    case (a)
      `UHD_OFS_CFG:    dec = 2'd0;
      `UHD_OFS_REQ:    dec = 2'd1;
      `UHD_OFS_RDATA:  dec = 2'd2;
      `UHD_OFS_STATUS: dec = 2'd3;
      default:         dec = 2'd2;
    endcase
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `UHD_OFS_CFG) || (a == `UHD_OFS_REQ) ||
             (a == `UHD_OFS_RDATA) || (a == `UHD_OFS_STATUS);
  endfunction

  uhd_rom u_rom (
    .cfg    (cfg_r),
    .req    (req_r),
    .byte_o (rom_byte),
    .hit    (rom_hit)
  );

  assign take      = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // ****************************************************************
  // Bus slave next state
  // ****************************************************************
  // Zero wait states; unmapped reads give zero, unmapped writes drop
  always_comb begin
    st_nxt     = take ? uhd_pkg::UHD_DATA : uhd_pkg::UHD_IDLE;
    addr_nxt   = take ? haddr : addr_r;
    wr_nxt     = take & hwrite;
    cfg_nxt    = cfg_r;
    req_nxt    = req_r;
    hrdata_nxt = hrdata_r;
    // Byte looked up one cycle after a request write settles
    byte_nxt   = rom_byte;
    hit_nxt    = rom_hit;
    case (st_r)
      uhd_pkg::UHD_DATA: begin
        if (wr_r && mapped(addr_r)) begin
          // Settings only change by software load
          if (dec(addr_r) == 2'd0) begin
            cfg_nxt.power_source_select =
              hwdata[`UHD_CFG_PSS_BIT];
            cfg_nxt.ports_off_when_bus_supplied =
              hwdata[`UHD_CFG_BPDIS_LSB +: 2];
            cfg_nxt.ports_off_when_self_supplied =
              hwdata[`UHD_CFG_SPDIS_LSB +: 2];
            cfg_nxt.bus_supplied_max_power =
              hwdata[`UHD_CFG_BPMAX_LSB +: 8];
            cfg_nxt.self_supplied_max_power =
              hwdata[`UHD_CFG_SPMAX_LSB +: 8];
          end else if (dec(addr_r) == 2'd1) begin
            req_nxt.index = hwdata[`UHD_REQ_IDX_LSB +: 8];
            req_nxt.dtype = hwdata[`UHD_REQ_TYPE_LSB +: 8];
          end
        end
      end
      uhd_pkg::UHD_IDLE: begin
      end
      default: begin
      end
    endcase
    // Read data prepared at the address phase, so it stands in data phase
    if (take && !hwrite) begin
      hrdata_nxt = 32'h0000_0000;
      if (mapped(haddr)) begin
        case (dec(haddr))
          2'd0: hrdata_nxt = {8'h00, cfg_r.self_supplied_max_power,
                              cfg_r.bus_supplied_max_power, 3'b000,
                              cfg_r.ports_off_when_self_supplied,
                              cfg_r.ports_off_when_bus_supplied,
                              cfg_r.power_source_select};
          2'd1: hrdata_nxt = {16'h0000, req_r.dtype, req_r.index};
          2'd2: hrdata_nxt = {24'h000000, byte_r};
          2'd3: hrdata_nxt = {31'h0000_0000, hit_r};
          default: hrdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Defaults stand in for the built-in configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r     <= uhd_pkg::UHD_IDLE;
      addr_r   <= 12'h000;
      wr_r     <= 1'b0;
      cfg_r    <= '{power_source_select:          1'b0,
                    ports_off_when_bus_supplied:  2'b00,
                    ports_off_when_self_supplied: 2'b00,
                    bus_supplied_max_power:       `UHD_RST_BPMAX,
                    self_supplied_max_power:      `UHD_RST_SPMAX};
      req_r    <= '{dtype: `UHD_DT_HUB, index: 8'h00};
      byte_r   <= 8'h00;
      hit_r    <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      st_r     <= st_nxt;
      addr_r   <= addr_nxt;
      wr_r     <= wr_nxt;
      cfg_r    <= cfg_nxt;
      req_r    <= req_nxt;
      byte_r   <= byte_nxt;
      hit_r    <= hit_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

endmodule

// ==== design/uhd_cfg.svh ====
/*
  Constants of the hub descriptor source: AHB register offsets, field
  positions, reset values and descriptor byte values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef UHD_CFG_SVH
`define UHD_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define UHD_OFS_CFG      12'h000
`define UHD_OFS_REQ      12'h004
`define UHD_OFS_RDATA    12'h008
`define UHD_OFS_STATUS   12'h00c

// ****************************************************************
// Configuration register fields and reset values
// ****************************************************************
`define UHD_CFG_PSS_BIT   0
`define UHD_CFG_BPDIS_LSB 1
`define UHD_CFG_SPDIS_LSB 3
`define UHD_CFG_BPMAX_LSB 8
`define UHD_CFG_SPMAX_LSB 16
`define UHD_RST_BPMAX     8'h32
`define UHD_RST_SPMAX     8'h01

// ****************************************************************
// Request register fields
// ****************************************************************
`define UHD_REQ_IDX_LSB   0
`define UHD_REQ_TYPE_LSB  8

// ****************************************************************
// Descriptor types and lengths
// ****************************************************************
`define UHD_DT_OSC        8'h07
`define UHD_DT_IFC        8'h04
`define UHD_DT_EP         8'h05
`define UHD_DT_HUB        8'h29
`define UHD_DT_HUB_OLD    8'h00
`define UHD_LEN_OSC       8'h09
`define UHD_LEN_IFC       8'h09
`define UHD_LEN_EP        8'h07
`define UHD_LEN_HUB       8'h09
`define UHD_TOTAL_LEN     16'h0019

// ****************************************************************
// Fixed descriptor byte values
// ****************************************************************
`define UHD_NUM_IFC       8'h01
`define UHD_CFG_VALUE     8'h01
`define UHD_STR_NONE      8'h00
`define UHD_ATTR_BUS      8'ha0
`define UHD_ATTR_SELF     8'he0
`define UHD_IFC_NUM       8'h00
`define UHD_ALT_SET       8'h00
`define UHD_NUM_EP        8'h01
`define UHD_CLASS_HUB     8'h09
`define UHD_SUBCLASS      8'h00
`define UHD_PROTOCOL      8'h00
`define UHD_EP_ADDR       8'h81
`define UHD_EP_ATTR       8'h03
`define UHD_EP_MPS        16'h0001
`define UHD_EP_INTERVAL   8'hff
`define UHD_NUM_PORTS     2'd3

`endif

// ==== design/uhd_pkg.sv ====
/*
  Types of the hub descriptor source.
  Assumes uhd_cfg.svh is compiled alongside; holds no constants itself.
*/
package uhd_pkg;

  // Power-related settings loaded at initialisation
  typedef struct packed {
    logic       power_source_select;
    logic [1:0] ports_off_when_bus_supplied;
    logic [1:0] ports_off_when_self_supplied;
    logic [7:0] bus_supplied_max_power;
    logic [7:0] self_supplied_max_power;
  } uhd_power_cfg_t;

  // One descriptor byte request
  typedef struct packed {
    logic [7:0] dtype;
    logic [7:0] index;
  } uhd_req_t;

  // Bus slave states
  typedef enum logic [0:0] {
    UHD_IDLE = 1'b0,
    UHD_DATA = 1'b1
  } uhd_state_t;

endpackage

// ==== design/uhd_rom.sv ====
/*
  Combinational descriptor byte table of the hub descriptor source.
  Assumes the caller registers the byte and validity it returns.
*/
`timescale 1ns/1ps
`include "uhd_cfg.svh"

module uhd_rom (
  input  wire uhd_pkg::uhd_power_cfg_t cfg,    // Loaded power settings
  input  wire uhd_pkg::uhd_req_t       req,    // Type and byte index
  output logic [7:0]                  byte_o, // Descriptor byte
  output logic                        hit     // Byte exists
);

  logic [7:0] attr;
  logic [7:0] maxp;
  logic [1:0] off;
  logic [1:0] nports;
  logic [15:0] mps;
  logic [15:0] tlen;

  // ****************************************************************
  // Power dependent values and fixed multi-byte fields
  // ****************************************************************
  // Only the two legal encodings can be produced
  assign attr = cfg.power_source_select ? `UHD_ATTR_SELF : `UHD_ATTR_BUS;
  // Loaded values passed unmodified
  assign maxp = cfg.power_source_select ? cfg.self_supplied_max_power
                                        : cfg.bus_supplied_max_power;
  assign off  = cfg.power_source_select ? cfg.ports_off_when_self_supplied
                                        : cfg.ports_off_when_bus_supplied;
  // Disabled count saturates so a bad load cannot wrap
  assign nports = (off > `UHD_NUM_PORTS) ? 2'd0 : `UHD_NUM_PORTS - off;
  assign mps  = `UHD_EP_MPS;
  // A literal cannot be part-selected, so the length goes through a net
  assign tlen = `UHD_TOTAL_LEN;

  // ****************************************************************
  // Byte table
  // ****************************************************************
  // Other-speed block holds config, interface and endpoint back to back
  always_comb begin
    byte_o = 8'h00;
    hit    = 1'b1;
    if (req.dtype == `UHD_DT_OSC) begin
      case (req.index)
        8'd0:  byte_o = `UHD_LEN_OSC;
        8'd1:  byte_o = `UHD_DT_OSC;
        8'd2:  byte_o = tlen[7:0];
        8'd3:  byte_o = tlen[15:8];
        8'd4:  byte_o = `UHD_NUM_IFC;
        8'd5:  byte_o = `UHD_CFG_VALUE;
        8'd6:  byte_o = `UHD_STR_NONE;
        8'd7:  byte_o = attr;
        8'd8:  byte_o = maxp;
        8'd9:  byte_o = `UHD_LEN_IFC;
        8'd10: byte_o = `UHD_DT_IFC;
        8'd11: byte_o = `UHD_IFC_NUM;
        8'd12: byte_o = `UHD_ALT_SET;
        8'd13: byte_o = `UHD_NUM_EP;
        8'd14: byte_o = `UHD_CLASS_HUB;
        8'd15: byte_o = `UHD_SUBCLASS;
        8'd16: byte_o = `UHD_PROTOCOL;
        8'd17: byte_o = `UHD_STR_NONE;
        8'd18: byte_o = `UHD_LEN_EP;
        8'd19: byte_o = `UHD_DT_EP;
        8'd20: byte_o = `UHD_EP_ADDR;
        8'd21: byte_o = `UHD_EP_ATTR;
        8'd22: byte_o = mps[7:0];
        8'd23: byte_o = mps[15:8];
        8'd24: byte_o = `UHD_EP_INTERVAL;
        default: hit = 1'b0;
      endcase
    end else if (req.dtype == `UHD_DT_HUB ||
                 req.dtype == `UHD_DT_HUB_OLD) begin
      // Same bytes at both speeds, so no speed input
      case (req.index)
        8'd0:    byte_o = `UHD_LEN_HUB;
        8'd1:    byte_o = `UHD_DT_HUB;
        8'd2:    byte_o = {6'h00, nports};
        default: hit = 1'b0;
      endcase
    end else begin
      hit = 1'b0;
    end
  end

endmodule

// ==== tb/uhd_top_sva.sv ====
/* Checker of descriptor bytes read back through RDATA.
   Assumes one master; REQ is written two edges before its read. */
`timescale 1ns/1ps
module uhd_top_sva (
  input wire logic        hclk,    // Bus clock
  input wire logic        hresetn, // Reset, low
  input wire logic        hsel,    // Select
  input wire logic [11:0] haddr,   // Address
  input wire logic [1:0]  htrans,  // Transfer
  input wire logic        hwrite,  // Write
  input wire logic [31:0] hwdata,  // Write data
  input wire logic        hready,  // Ready
  input wire logic [31:0] hrdata   // Read data
);
  localparam logic [71:0] ifc_bytes = 72'h090400000109000000;
  localparam logic [55:0] ep_bytes  = 56'h070581030100ff;
  logic [23:0] cfg_r;
  logic [15:0] req_r;
  logic [11:0] adr_r;
  logic [7:0]  ix;
  logic [1:0]  age_r, dis;
  logic        wr_r, rd, osc, hub;
  // ********************
  // Mirror of REQ and CFG
  // ********************
  // A write restarts the age, since the lookup lags it by a cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_r, adr_r, age_r, req_r, cfg_r} <= {15'h0, 16'h2900, 24'h013200};
    end else begin
      wr_r  <= hsel & hready & htrans[1] & hwrite;
      adr_r <= haddr;
      if (wr_r && adr_r == 12'h004) req_r <= hwdata[15:0];
      if (wr_r && adr_r == 12'h000) cfg_r <= hwdata[23:0];
      age_r <= wr_r ? 2'h0 : age_r + {1'b0, ~&age_r};
    end
  end
  // Settled reads of RDATA only
  assign rd  = hsel & hready & htrans[1] & !hwrite & (haddr == 12'h008)
             & age_r[1];
  assign ix  = req_r[7:0];
  assign dis = cfg_r[0] ? cfg_r[4:3] : cfg_r[2:1];
  assign osc = rd & (req_r[15:8] == 8'h07);
  assign hub = rd & (req_r[15:8] == 8'h29 | req_r[15:8] == 8'h00);
  // ********************
  // Bytes in each data phase
  // ********************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  total_len_a: assert property (osc && ix inside {2, 3}
    |=> hrdata[7:0] == (ix[0] ? 8'h00 : 8'h19)) else $error("bad length");
  osc_fixed_a: assert property (osc && ix inside {[4:6]}
    |=> hrdata[7:0] == (ix == 6 ? 8'h00 : 8'h01)) else $error("bad config");
  attr_sel_a: assert property (osc && ix == 7
    |=> hrdata[7:0] == (cfg_r[0] ? 8'he0 : 8'ha0)) else $error("bad attr");
  max_pwr_a: assert property (osc && ix == 8
    |=> hrdata[7:0] == (cfg_r[0] ? cfg_r[23:16] : cfg_r[15:8]))
    else $error("bad max power");
  ifc_desc_a: assert property (osc && ix inside {[9:17]}
    |=> hrdata[7:0] == ifc_bytes[143-8*ix -: 8]) else $error("bad ifc");
  ep_desc_a:
    assert property (osc && ix inside {[18:24]}
    |=> hrdata[7:0] == ep_bytes[199-8*ix -: 8]) else $error("bad endpoint");
  hub_head_a: assert property (hub && ix < 2
    |=> hrdata[7:0] == (ix[0] ? 8'h29 : 8'h09)) else $error("bad hub head");
  port_cnt_a: assert property (hub && ix == 2
    |=> hrdata[7:0] == {6'h00, 2'h3 - dis}) else $error("bad port count");
endmodule
bind uhd_top uhd_top_sva chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata));

// ==== tb/uhd_host_model.sv ====
/* Host model: single word AHB-Lite transfers and byte requests.
   Assumes hready is the slave's hreadyout. */
`timescale 1ns/1ps
module uhd_host_model (
  input  wire logic        hclk,   // Bus clock
  input  wire logic        hready, // Ready
  input  wire logic [31:0] hrdata, // Read data
  output logic             hsel,   // Select
  output logic      [11:0] haddr,  // Address
  output logic      [1:0]  htrans, // Transfer
  output logic             hwrite, // Write
  output logic      [2:0]  hsize,  // Word size
  output logic      [31:0] hwdata  // Write data
);
  // Idle bus from time zero
  initial begin
    {hsel, htrans, hwrite, haddr} = '0;
    hsize  = 3'h2;
    hwdata = 32'h5a5a5a5a;
  end
  // Hold each phase until ready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    if (w) hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata; // Released lines must not keep the old word
  endtask
  // Request a byte, wait out the lookup, then read byte and hit flag
  task automatic fetch(input logic [7:0] ty, input logic [7:0] ix,
                       output logic [7:0] b, output logic h);
    logic [31:0] q;
    xfer(1'b1, 12'h004, {16'h0000, ty, ix}, q);
    repeat (2) @(posedge hclk);
    xfer(1'b0, 12'h008, 32'h0, q);
    b = q[7:0];
    xfer(1'b0, 12'h00c, 32'h0, q);
    h = q[0];
  endtask
endmodule

// ==== tb/usb_hub_descriptor_source_test.sv ====
/* Bench of the hub descriptor source: reset values, all bytes under
   several power settings, hub header and port count.
   Assumes the host model is the only bus master. */
`timescale 1ns/1ps
module usb_hub_descriptor_source_test;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, h;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [7:0]  b;
  int          errors, checks_done, cycles;
  uhd_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));
  uhd_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  // 20 MHz clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Expected other-speed block byte under power setting c
  function automatic logic [7:0] osc_exp(int i, logic [23:0] c);
    logic [199:0] t;
    t = 200'h090719000101000000090400000109000000070581030100ff;
    if (i == 7) return c[0] ? 8'he0 : 8'ha0;
    if (i == 8) return c[0] ? c[23:16] : c[15:8];
    return t[199-8*i -: 8];
  endfunction
  // The byte must exist and match
  task automatic want(input logic [7:0] ty, ix, exp);
    host.fetch(ty, ix, b, h);
    chk({24'h0, b}, {24'h0, exp});
    chk({31'h0, h}, 32'h1);
  endtask
  task automatic t_regs;
    host.xfer(1'b0, 12'h000, 32'h0, q);
    chk(q, 32'h00013200);
    host.xfer(1'b0, 12'h004, 32'h0, q);
    chk(q, 32'h00002900);
    chk({30'h0, hreadyout, hresp}, 32'h2); // Always ready, always OKAY
    host.xfer(1'b1, 12'h010, 32'hffffffff, q);
    host.xfer(1'b0, 12'h010, 32'h0, q);
    chk(q, 32'h0);
    $display("test regs done");
  endtask
  // Extreme max power values 00 and ff each sit once in the selected and once in the unselected slot
  task automatic t_desc;
    logic [23:0] cf [4] = '{24'h013200, 24'h00ff01, 24'h7a0500, 24'hff0001};
    for (int k = 0; k < 4; k++) begin
      host.xfer(1'b1, 12'h000, {8'h00, cf[k]}, q);
      for (int i = 0; i < 25; i++)
        want(8'h07, i[7:0], osc_exp(i, cf[k]));
      host.fetch(8'h07, 8'd25, b, h);
      chk({31'h0, h}, 32'h0);
    end
    $display("test descriptors done");
  endtask
  task automatic t_hub;
    logic [7:0] cf [4] = '{8'h1a, 8'h1b, 8'h00, 8'h17};
    logic [7:0] np [4] = '{8'h02, 8'h00, 8'h03, 8'h01};
    logic [7:0] ty;
    for (int k = 0; k < 8; k++) begin
      ty = k[0] ? 8'h00 : 8'h29;
      host.xfer(1'b1, 12'h000, {24'h000132, cf[k/2]}, q);
      want(ty, 8'h00, 8'h09);
      want(ty, 8'h01, 8'h29);
      want(ty, 8'h02, np[k/2]);
    end
    host.fetch(8'h02, 8'h00, b, h);
    chk({31'h0, h}, 32'h0);
    $display("test hub done");
  endtask
  // The tests need about 1070 cycles
  initial begin
    cycles = 0;
    forever begin
      @(posedge hclk);
      cycles++;
      if (cycles == 5000) begin
        errors++;
        end_of_test;
      end
    end
  end
  initial begin
    errors      = 0;
    checks_done = 0;
    hresetn     = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_desc;
    t_hub;
    end_of_test;
  end
endmodule
